// >>> hw/tfs_top.sv
// Table-access flash self-programmer: pointer, latch, holding registers, sequencer
module tfs_top
	import tfs_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int ABORT_AT_RESET = 1
) (
	input wire logic CLK,
	input wire logic RESET_N,
	// Core special-register port, byte wide
	input wire logic PTRU_WR,
	input wire logic PTRH_WR,
	input wire logic PTRL_WR,
	input wire logic LATCH_WR,
	input wire logic CTRL_WR,
	input wire logic UNLOCK_WR,
	input wire logic [7:0] WDATA,
	// Table instructions
	input wire logic FETCH_OP,
	input wire logic LOAD_OP,
	input wire logic [1:0] PTR_MODE,
	// Read-back
	output logic [7:0] POINTER_UPPER_BYTE,
	output logic [7:0] POINTER_HIGH_BYTE,
	output logic [7:0] POINTER_LOW_BYTE,
	output logic [7:0] TRANSFER_LATCH,
	output logic [7:0] FLASH_CONTROL_REG,
	output logic [7:0] FLASH_UNLOCK_REG,
	output logic CORE_STALL,
	// Flash array side
	output logic [PTR_W-1:0] ARR_RADDR,
	input wire logic [7:0] ARR_RDATA,
	output logic ARR_ERASE,
	output logic [PTR_W-1:0] ARR_EADDR,
	output logic ARR_WVALID,
	input wire logic ARR_WREADY,
	output logic [PTR_W-1:0] ARR_WADDR,
	output logic [7:0] ARR_WDATA
);
	logic [1:0] rsync_q;
	wire rst_n = rsync_q[1];
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			rsync_q <= 2'b00;
		else
			rsync_q <= {rsync_q[0], 1'b1};
	end

	logic [PTR_W-1:0] ptr_q;
	logic [7:0] latch_q;
	logic [7:0] ctl_q;
	logic [7:0] hold [HOLD_N];
	tfs_lock_e lock_q;
	tfs_seq_e seq_q;
	logic [31:0] tmr_q;
	logic [HOLD_AW:0] idx_q;
	logic [HOLD_AW:0] cnt_q;
	logic fetch_pend_q;
	logic [PTR_W-1:0] blk_q;
	logic word_program_select_run_q;
	logic fifo_in_valid;
	logic fifo_in_ready;
	tfs_beat_s fifo_in;
	tfs_beat_s fifo_out;
	logic fifo_out_valid;
	logic fifo_take;

	tfs_ptrmode_e pmode;
	assign pmode = tfs_ptrmode_e'(PTR_MODE);
	wire table_op = (FETCH_OP || LOAD_OP) && (seq_q == SQ_IDLE);
	// Steps wrap inside the low field so the space-select bit never moves
	wire [LOW_W-1:0] low_inc = ptr_q[LOW_W-1:0] + 1'b1; // RULE_05
	wire [LOW_W-1:0] low_dec = ptr_q[LOW_W-1:0] - 1'b1; // RULE_05
	wire [PTR_W-1:0] ptr_inc = {ptr_q[PTR_W-1], low_inc}; // RULE_03
	wire [PTR_W-1:0] ptr_dec = {ptr_q[PTR_W-1], low_dec};
	wire [PTR_W-1:0] acc_addr = (pmode == PTR_PREINC) ? ptr_inc : ptr_q; // RULE_04
	wire [PTR_W-1:0] ptr_after = (pmode == PTR_POSTINC || pmode == PTR_PREINC) ? ptr_inc :
		(pmode == PTR_POSTDEC) ? ptr_dec : ptr_q; // RULE_04
	wire [HOLD_AW-1:0] hold_sel = acc_addr[HOLD_AW-1:0]; // RULE_07

	// Go bit accepted only right after a full unlock and with write-allow
	wire go_req = CTRL_WR && WDATA[CTL_GO] && !ctl_q[CTL_GO];
	wire allow = (lock_q == LK_OPEN) && WDATA[CTL_WALLOW] && seq_q == SQ_IDLE; // RULE_24
	wire launch = go_req && allow; // RULE_12
	wire bad_go = go_req && !allow; // RULE_22
	wire erase_sel = WDATA[CTL_ERASE];
	wire [PTR_W-1:0] blk_base = {ptr_q[PTR_W-1:BLK_LSB], {BLK_LSB{1'b0}}}; // RULE_08 RULE_09

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= '0;
			latch_q <= 8'h00;
			fetch_pend_q <= 1'b0;
		end else begin
			fetch_pend_q <= 1'b0;
			if (table_op) begin
				ptr_q <= ptr_after; // RULE_04
				if (FETCH_OP)
					fetch_pend_q <= 1'b1;
			end else begin
				if (PTRU_WR)
					ptr_q[PTR_W-1:16] <= WDATA[PTR_W-17:0]; // RULE_01
				if (PTRH_WR)
					ptr_q[15:8] <= WDATA;
				if (PTRL_WR)
					ptr_q[7:0] <= WDATA;
			end
			if (fetch_pend_q)
				latch_q <= ARR_RDATA; // RULE_06
			else if (LATCH_WR)
				latch_q <= WDATA;
		end
	end

	// Full 22-bit address; the array picks the word byte by bit 0
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			ARR_RADDR <= '0;
		else if (table_op && FETCH_OP)
			ARR_RADDR <= acc_addr; // RULE_02 RULE_06 RULE_10
	end

	// Holding registers only; never cleared, so they survive programming
	always_ff @(posedge CLK) begin
		if (table_op && LOAD_OP && !FETCH_OP)
			hold[hold_sel] <= latch_q; // RULE_07 RULE_16 RULE_18
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			lock_q <= LK_IDLE;
		else if (UNLOCK_WR)
			lock_q <= (WDATA == UNLOCK_1) ? LK_GOT55 :
				(lock_q == LK_GOT55 && WDATA == UNLOCK_2) ? LK_OPEN : LK_IDLE; // RULE_12
		else if (CTRL_WR || PTRU_WR || PTRH_WR || PTRL_WR || LATCH_WR || table_op)
			lock_q <= LK_IDLE; // RULE_12
	end

	wire fin = (seq_q == SQ_DONE);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			// Reset leaves the abort flag up, as if an operation was cut short
			ctl_q <= CTL_RESET | ((ABORT_AT_RESET != 0) ? (8'h01 << CTL_ABORT) : 8'h00); // RULE_22
		end else begin
			if (CTRL_WR)
				ctl_q[CTL_WORD_PROGRAM_SELECT:CTL_WALLOW] <= (WDATA[CTL_WORD_PROGRAM_SELECT:CTL_WALLOW] & CTL_WMASK[5:2])
					| (ctl_q[CTL_WORD_PROGRAM_SELECT:CTL_WALLOW] & 4'b0010);
			if (launch) begin
				ctl_q[CTL_GO] <= 1'b1; // RULE_21
				ctl_q[CTL_ABORT] <= 1'b1; // RULE_22
			end else if (bad_go) begin
				ctl_q[CTL_ABORT] <= 1'b1; // RULE_22
			end
			if (fin) begin
				ctl_q[CTL_GO] <= 1'b0; // RULE_21
				ctl_q[CTL_ABORT] <= 1'b0; // RULE_22
				if (!word_program_select_run_q)
					ctl_q[CTL_ERASE] <= 1'b0;
				if (blk_q[0])
					ctl_q[CTL_ERASE] <= 1'b0; // RULE_23
			end
		end
	end

	// Sequencer: erase pulse or holding-register stream, then the programming timer
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			seq_q <= SQ_IDLE;
			tmr_q <= '0;
			idx_q <= '0;
			cnt_q <= '0;
			blk_q <= '0;
			word_program_select_run_q <= 1'b0;
			ARR_ERASE <= 1'b0;
			ARR_EADDR <= '0;
			CORE_STALL <= 1'b0;
		end else begin
			ARR_ERASE <= 1'b0;
			case (seq_q)
				SQ_IDLE: begin
					if (launch) begin
						CORE_STALL <= 1'b1; // RULE_13
						blk_q <= {blk_base[PTR_W-1:1], erase_sel};
						word_program_select_run_q <= WDATA[CTL_WORD_PROGRAM_SELECT];
						if (erase_sel) begin
							seq_q <= SQ_ERASE; // RULE_14
						end else begin
							seq_q <= SQ_PROG;
							// Word mode writes the aligned pair picked by pointer bits 5..1, inside the first 64 bytes of the block
							idx_q <= WDATA[CTL_WORD_PROGRAM_SELECT] ?
								{1'b0, ptr_q[HOLD_AW-1:1], 1'b0} : '0; // RULE_20
							cnt_q <= WDATA[CTL_WORD_PROGRAM_SELECT] ? (HOLD_AW+1)'(WORD_BYTES) :
								(HOLD_AW+1)'(HOLD_N); // RULE_15
						end
					end
				end
				SQ_ERASE: begin
					ARR_ERASE <= 1'b1; // RULE_09
					ARR_EADDR <= {blk_q[PTR_W-1:1], 1'b0};
					tmr_q <= 32'(ERASE_CYCLES);
					seq_q <= SQ_WAIT;
				end
				SQ_PROG: begin
					if (fifo_in_ready) begin
						idx_q <= idx_q + 1'b1;
						cnt_q <= cnt_q - 1'b1;
						if (cnt_q == (HOLD_AW+1)'(1)) begin
							tmr_q <= 32'(PROG_CYCLES);
							seq_q <= SQ_WAIT;
						end
					end
				end
				SQ_WAIT: begin
					// Timer only ends once every beat reached the array
					if (tmr_q > 32'd1)
						tmr_q <= tmr_q - 32'd1;
					else if (!fifo_out_valid && !ARR_WVALID)
						seq_q <= SQ_DONE; // RULE_13
				end
				SQ_DONE: begin
					CORE_STALL <= 1'b0;
					seq_q <= SQ_IDLE;
				end
				default: seq_q <= SQ_IDLE;
			endcase
		end
	end

	assign fifo_in_valid = (seq_q == SQ_PROG);
	assign fifo_in.addr = {blk_q[PTR_W-1:BLK_LSB], 4'h0, idx_q[HOLD_AW-1:0]}; // RULE_08
	assign fifo_in.data = hold[idx_q[HOLD_AW-1:0]];

	tfs_fifo #(
		.WIDTH(BEAT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_take),
		.out_data(fifo_out)
	);

	// Refill the beat register as it empties, so the array port never idles between beats
	assign fifo_take = fifo_out_valid && (!ARR_WVALID || ARR_WREADY);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ARR_WVALID <= 1'b0;
			ARR_WADDR <= '0;
			ARR_WDATA <= 8'h00;
		end else if (fifo_take) begin
			ARR_WVALID <= 1'b1; // RULE_16
			ARR_WADDR <= fifo_out.addr;
			ARR_WDATA <= fifo_out.data;
		end else if (ARR_WREADY) begin
			ARR_WVALID <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			POINTER_UPPER_BYTE <= 8'h00;
			POINTER_HIGH_BYTE <= 8'h00;
			POINTER_LOW_BYTE <= 8'h00;
			TRANSFER_LATCH <= 8'h00;
			FLASH_CONTROL_REG <= 8'h00;
			FLASH_UNLOCK_REG <= 8'h00;
		end else begin
			POINTER_UPPER_BYTE <= {2'b00, ptr_q[PTR_W-1:16]};
			POINTER_HIGH_BYTE <= ptr_q[15:8];
			POINTER_LOW_BYTE <= ptr_q[7:0];
			TRANSFER_LATCH <= latch_q;
			FLASH_CONTROL_REG <= ctl_q & 8'h3e;
			FLASH_UNLOCK_REG <= 8'h00; // RULE_25
		end
	end

	chk_stall_on_launch: assert property (@(posedge CLK) disable iff (!rst_n)
		launch |=> CORE_STALL) else $error("stall missing after launch"); // RULE_13
	chk_no_locked_go: assert property (@(posedge CLK) disable iff (!rst_n)
		(go_req && lock_q != LK_OPEN) |=> seq_q == SQ_IDLE) else $error("locked go ran"); // RULE_24
	chk_go_sticky: assert property (@(posedge CLK) disable iff (!rst_n)
		(ctl_q[CTL_GO] && !fin) |=> ctl_q[CTL_GO]) else $error("go cleared early"); // RULE_21
	chk_go_clears: assert property (@(posedge CLK) disable iff (!rst_n)
		fin |=> !ctl_q[CTL_GO] && !ctl_q[CTL_ABORT]) else $error("go not cleared"); // RULE_22
	chk_top_bit_kept: assert property (@(posedge CLK) disable iff (!rst_n)
		table_op |=> ptr_q[PTR_W-1] == $past(ptr_q[PTR_W-1])) else $error("top bit moved"); // RULE_05
	chk_fetch_latch: assert property (@(posedge CLK) disable iff (!rst_n)
		fetch_pend_q |=> latch_q == $past(ARR_RDATA)) else $error("latch not loaded"); // RULE_06
	chk_erase_block: assert property (@(posedge CLK) disable iff (!rst_n)
		ARR_ERASE |-> ARR_EADDR[BLK_LSB-1:0] == '0) else $error("erase not aligned"); // RULE_09
	chk_erase_clr: assert property (@(posedge CLK) disable iff (!rst_n)
		(fin && blk_q[0]) |=> !ctl_q[CTL_ERASE]) else $error("erase select kept"); // RULE_23
	chk_unlock_zero: assert property (@(posedge CLK) disable iff (!rst_n)
		##1 FLASH_UNLOCK_REG == 8'h00) else $error("unlock reads nonzero"); // RULE_25
endmodule

// >>> hw/tfs_pkg.sv
// Constants, types and rule summary for the table-access flash self-programmer
// What this block does
// [RULE_01] Pointer is upper, high and low bytes joined into 22 bits.
// [RULE_02] Low 21 pointer bits address up to 2 Mbytes of program memory.
// [RULE_03] Top pointer bit selects the ID and configuration space instead.
// [RULE_04] Each table access leaves, post-increments, post-decrements or pre-increments pointer.
// [RULE_05] Automatic pointer steps touch only the low 21 bits.
// [RULE_06] Table read fetches the byte at the full 22-bit pointer into latch.
// [RULE_07] Table write stores latch into holding register chosen by pointer bits 5..0.
// [RULE_08] At launch, pointer bits 21..10 choose the 1024-byte target block.
// [RULE_09] Erase clears the whole selected block, ignoring pointer bits 9..0.
// [RULE_10] Lowest address bit picks high or low byte of a flash word.
// [RULE_11] Software sets write-allow and erase-select before an erase launch.
// [RULE_12] Launch needs 0x55 then 0xAA to unlock register, then go bit.
// [RULE_13] Instruction execution stalls until the programming timer ends the operation.
// [RULE_14] Self erase works only on whole 1024-byte blocks.
// [RULE_15] Programming writes a 64-byte block or one 2-byte word per launch.
// [RULE_16] Table writes only load holding registers; array changes on long write.
// [RULE_17] Software fills up to 64 holding registers, then starts the long write.
// [RULE_18] Holding registers keep contents after programming completes.
// [RULE_19] Software should program each byte once between erases.
// [RULE_20] Word-program select 1 programs 2 bytes, 0 programs 64 bytes.
// [RULE_21] Go bit is set-only by software, cleared by hardware at completion.
// [RULE_22] Abort flag set on reset-cut or improper launch, zero after normal completion.
// [RULE_23] Hardware clears erase-select when an erase completes.
// [RULE_24] Go without full unlock, or with write-allow clear, starts nothing.
// [RULE_25] Unlock register reads as zero and stores only sequence progress.
package tfs_pkg;
	localparam int PTR_W = 22;
	localparam int LOW_W = 21;
	localparam int HOLD_N = 64;
	localparam int HOLD_AW = 6;
	localparam int BLK_LSB = 10;
	localparam int WORD_BYTES = 2;
	localparam logic [7:0] UNLOCK_1 = 8'h55;
	localparam logic [7:0] UNLOCK_2 = 8'haa;
	localparam int CTL_WORD_PROGRAM_SELECT = 5;
	localparam int CTL_ERASE = 4;
	localparam int CTL_ABORT = 3;
	localparam int CTL_WALLOW = 2;
	localparam int CTL_GO = 1;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] CTL_WMASK = 8'h34;
	localparam int ERASE_NS = 2800000;
	localparam int PROG_NS = 2800000;
	localparam int CLK_NS = 40;
	localparam int ERASE_CYC = ERASE_NS / CLK_NS;
	localparam int PROG_CYC = PROG_NS / CLK_NS;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	typedef enum logic [1:0] {
		PTR_KEEP = 2'b00,
		PTR_POSTINC = 2'b01,
		PTR_POSTDEC = 2'b10,
		PTR_PREINC = 2'b11
	} tfs_ptrmode_e;

	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_GOT55 = 2'b01,
		LK_OPEN = 2'b10
	} tfs_lock_e;

	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000,
		SQ_ERASE = 3'b001,
		SQ_PROG = 3'b010,
		SQ_WAIT = 3'b011,
		SQ_DONE = 3'b100
	} tfs_seq_e;

	// One flash array write beat: address and byte
	typedef struct packed {
		logic [PTR_W-1:0] addr;
		logic [7:0] data;
	} tfs_beat_s;

	localparam int BEAT_W = PTR_W + 8;
endpackage

// >>> hw/tfs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module tfs_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = wp_q != rp_q;
	assign out_data = mem[rp_q[AW-1:0]];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wp_q[AW-1:0]] <= in_data;
	end
endmodule

// >>> dv/tfs_flash_model.sv
// Flash array model: byte store, block erase, stallable write port
module tfs_flash_model
	import tfs_pkg::*;
(
	input wire logic clk,
	input wire logic slow,
	input wire logic [PTR_W-1:0] raddr,
	output logic [7:0] rdata,
	input wire logic erase,
	input wire logic [PTR_W-1:0] eaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [PTR_W-1:0] waddr,
	input wire logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [logic [PTR_W-1:0]];
	int beats = 0;
	// Unwritten cells hold an address pattern, so a wrong address reads wrong data
	function automatic logic [7:0] peek(logic [PTR_W-1:0] a);
		return mem.exists(a) ? mem[a] : a[7:0] ^ {a[21:18], a[13:10]};
	endfunction
	initial begin
		rdata = 8'h00;
		wready = 1'b0;
	end
	// Read data settles mid-cycle, in time for the edge after the address is registered
	always @(negedge clk) rdata <= peek(raddr);
	always @(posedge clk) begin
		wready <= slow ? !wready : 1'b1;
		if (erase) begin
			for (int i = 0; i < 1024; i++) mem[{eaddr[21:10], 10'(i)}] = ERASED_BYTE;
		end
		if (wvalid && wready) begin
			mem[waddr] = wdata;
			beats++;
		end
	end
endmodule

// >>> dv/table_access_flash_self_programmer_test.sv
// Self-checking bench for the table-access flash self-programmer
module table_access_flash_self_programmer_test;
	import tfs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, fop = 0, lop = 0, slow = 0, stall, er, wv, wrdy;
	logic [5:0] stb = '0;
	logic [7:0] wd = '0, pu, ph, pl, lat, ctl, unl, rd, wdat;
	logic [1:0] md = '0;
	logic [PTR_W-1:0] ra, ea, wa, a, b;
	logic [31:0] r = 32'h7bfe;
	logic [7:0] dat [HOLD_N];
	int n_errors = 0, tests_run = 0, k;
	tfs_top #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) tfs_top_i (.CLK(clk), .RESET_N(rst_n),
		.PTRU_WR(stb[0]), .PTRH_WR(stb[1]), .PTRL_WR(stb[2]), .LATCH_WR(stb[3]),
		.CTRL_WR(stb[4]), .UNLOCK_WR(stb[5]), .WDATA(wd), .FETCH_OP(fop), .LOAD_OP(lop),
		.PTR_MODE(md), .POINTER_UPPER_BYTE(pu), .POINTER_HIGH_BYTE(ph),
		.POINTER_LOW_BYTE(pl), .TRANSFER_LATCH(lat), .FLASH_CONTROL_REG(ctl),
		.FLASH_UNLOCK_REG(unl), .CORE_STALL(stall), .ARR_RADDR(ra), .ARR_RDATA(rd),
		.ARR_ERASE(er), .ARR_EADDR(ea), .ARR_WVALID(wv), .ARR_WREADY(wrdy),
		.ARR_WADDR(wa), .ARR_WDATA(wdat));
	tfs_flash_model tfs_flash_model_i (.clk(clk), .slow(slow), .raddr(ra), .rdata(rd),
		.erase(er), .eaddr(ea), .wvalid(wv), .wready(wrdy), .waddr(wa), .wdata(wdat));
	initial forever #20 clk = ~clk;
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(string s, logic [23:0] e, logic [23:0] g);
		tests_run++;
		if (e !== g) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// Idle cycle after each strobe keeps every assignment in its own time step
	task automatic wr(int s, logic [7:0] d);
		stb = 6'(1 << s);
		wd = d;
		@(posedge clk) #2;
		stb = '0;
		@(posedge clk) #2;
	endtask
	task automatic setp(logic [PTR_W-1:0] p);
		wr(0, 8'(p[21:16]));
		wr(1, p[15:8]);
		wr(2, p[7:0]);
	endtask
	task automatic tbl(logic f, logic [1:0] m);
		fop = f;
		lop = !f;
		md = m;
		@(posedge clk) #2;
		fop = 0;
		lop = 0;
		repeat (3) @(posedge clk);
		#2;
	endtask
	task automatic launch(logic [7:0] c, logic ok);
		int n = 0;
		wr(5, UNLOCK_1);
		check("unlock read", 0, unl);
		wr(5, UNLOCK_2);
		wr(4, c);
		check("stall", ok, stall);
		while (stall && n < 300) begin
			@(posedge clk) #2;
			n++;
		end
		repeat (2) @(posedge clk);
		#2;
		check("stall ends", 0, stall);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		results;
	end
	initial begin
		repeat (3) @(posedge clk);
		#2 rst_n = 1;
		repeat (3) @(posedge clk);
		#2;
		check("ctl reset", 8'h08, ctl);
		// Top-bit corners first, then random pointers
		for (int i = 0; i < 8; i++) begin
			r = lfsr(r);
			a = (i < 2) ? {i[0], {21{!i[0]}}} : r[21:0];
			md = 2'(i + 1);
			setp(a);
			check("pointer", {2'b00, a}, {pu, ph, pl});
			b = (md == PTR_PREINC) ? {a[21], a[20:0] + 21'd1} : a;
			tbl(1, 2'(i + 1));
			check("fetch", tfs_flash_model_i.peek(b), lat);
			if (md[0]) b = {a[21], a[20:0] + 21'd1};
			if (md == PTR_POSTDEC) b = {a[21], a[20:0] - 21'd1};
			check("pointer step", {2'b00, b}, {pu, ph, pl});
		end
		$display("test pointer and fetch done");
		r = lfsr(r);
		a = {1'b0, r[20:10], 10'h000};
		setp(a);
		k = tfs_flash_model_i.beats;
		for (int i = 0; i < HOLD_N; i++) begin
			r = lfsr(r);
			dat[i] = r[7:0];
			wr(3, dat[i]);
			tbl(0, PTR_POSTINC);
		end
		check("short writes", k, tfs_flash_model_i.beats);
		launch(8'h06, 1);
		check("block beats", k + 64, tfs_flash_model_i.beats);
		check("ctl done", 8'h04, ctl);
		for (int i = 0; i < HOLD_N; i++) check("array", dat[i], tfs_flash_model_i.peek(a + i));
		slow = 1;
		setp(a + 22'h406);
		launch(8'h26, 1);
		check("word beats", k + 66, tfs_flash_model_i.beats);
		check("word hi", dat[7], tfs_flash_model_i.peek(a + 22'h407));
		check("word lo", dat[6], tfs_flash_model_i.peek(a + 22'h406));
		slow = 0;
		$display("test programming done");
		r = lfsr(r);
		setp({a[21:10], r[9:0]});
		launch(8'h16, 1);
		check("erase clears select", 8'h04, ctl);
		for (int i = 0; i < 1024; i += 341) check("erased", ERASED_BYTE, tfs_flash_model_i.peek(a + i));
		check("next block kept", dat[6], tfs_flash_model_i.peek(a + 22'h406));
		$display("test erase done");
		wr(5, UNLOCK_2);
		wr(5, UNLOCK_1);
		wr(4, 8'h06);
		check("swapped unlock", 0, stall);
		wr(5, UNLOCK_1);
		wr(2, 8'h00);
		wr(5, UNLOCK_2);
		wr(4, 8'h06);
		check("broken unlock", 0, stall);
		check("abort set", 8'h0c, ctl);
		launch(8'h02, 0);
		check("no write allow", 8'h08, ctl);
		$display("test refusals done");
		// A reset in the middle of an erase must cut it and leave the abort flag up
		wr(5, UNLOCK_1);
		wr(5, UNLOCK_2);
		wr(4, 8'h16);
		check("cut stall", 1, stall);
		rst_n = 0;
		repeat (3) @(posedge clk);
		#2 rst_n = 1;
		repeat (3) @(posedge clk);
		#2;
		check("cut abort", 8'h08, ctl);
		check("cut stall off", 0, stall);
		launch(8'h16, 1);
		check("erase after cut", 8'h04, ctl);
		$display("test reset cut done");
		results;
	end
endmodule
